/* File: alu_unit.sv */
// Byte-wide arithmetic and logic unit with its four flags.
// Purely combinational; affect_o tells the caller which flags the operation changes.
`timescale 1ns/10ps
`default_nettype none

module alu_unit (
    // Operands
    input  wire logic [7:0]        a_i,
    input  wire logic [7:0]        b_i,
    input  wire logic              carry_i,
    input  wire core_pkg::alu_op_t op_i,
    // Results
    output logic [7:0]             result_o,
    output core_pkg::flags_t       flags_o,
    output core_pkg::flags_t       affect_o
);
    logic       subtract;
    logic [7:0] addend;
    logic [4:0] low_sum;
    logic [7:0] mag_sum;
    logic [8:0] full_sum;

    // Subtraction is b minus a in two's complement, so carry set means no borrow.
    assign subtract = (op_i == core_pkg::ALU_SUB);
    assign addend   = subtract ? ~a_i : a_i;
    assign low_sum  = {1'b0, b_i[3:0]} + {1'b0, addend[3:0]} + {4'h0, subtract};
    assign mag_sum  = {1'b0, b_i[6:0]} + {1'b0, addend[6:0]} + {7'h00, subtract};
    assign full_sum = {1'b0, b_i} + {1'b0, addend} + {8'h00, subtract};

    always_comb begin
        result_o   = full_sum[7:0];
        flags_o.c  = full_sum[8];
        flags_o.dc = low_sum[4];
        // Carry into the sign bit against carry out of it, within this byte only.
        flags_o.ov = mag_sum[7] ^ full_sum[8];
        affect_o   = '{ov: 1'b0, z: 1'b1, dc: 1'b0, c: 1'b0};
        unique case (op_i)
            core_pkg::ALU_ADD, core_pkg::ALU_SUB: begin
                affect_o = '{default: 1'b1};
            end
            core_pkg::ALU_AND: begin
                result_o = a_i & b_i;
            end
            core_pkg::ALU_IOR: begin
                result_o = a_i | b_i;
            end
            core_pkg::ALU_XOR: begin
                result_o = a_i ^ b_i;
            end
            core_pkg::ALU_RLC: begin
                result_o  = {b_i[6:0], carry_i};
                flags_o.c = b_i[7];
                affect_o  = '{ov: 1'b0, z: 1'b0, dc: 1'b0, c: 1'b1};
            end
            core_pkg::ALU_RRC: begin
                result_o  = {carry_i, b_i[7:1]};
                flags_o.c = b_i[0];
                affect_o  = '{ov: 1'b0, z: 1'b0, dc: 1'b0, c: 1'b1};
            end
            core_pkg::ALU_PASS: begin
                result_o = b_i;
            end
        endcase
        flags_o.z = (result_o == 8'h00);
    end

endmodule : alu_unit

`default_nettype wire

/* File: core_params.svh */
// Constants of the byte-wide core: bus offsets, field positions, data-space
// addresses of the special registers, opcodes and reset values.
// Holds definitions only; the core and the bench include it by its bare name.
`ifndef CORE_PARAMS_SVH
`define CORE_PARAMS_SVH

// APB byte offsets, one aligned word each.
`define OFS_CTRL      8'h00
`define OFS_ACC       8'h04
`define OFS_STATUS    8'h08
`define OFS_PC        8'h0c
`define OFS_PRODUCT   8'h10
`define OFS_CORE      8'h14

// Control and core-state register fields.
`define CTRL_RUN      0
`define CTRL_MODE_LO  4
`define CTRL_MODE_HI  5
`define CORE_EXT      0
`define CORE_PROT     1
`define CORE_VALID    2

// Special registers in data space.
`define SFR_ACC       8'h00
`define SFR_STATUS    8'h01
`define SFR_PC_LO     8'h02
`define SFR_PC_HI     8'h03
`define SFR_PROD_LO   8'h04
`define SFR_LAST      8'h05

// Instruction fields and opcodes in bits 15:12.
`define DEST_BIT      8
`define OPC_NOP       4'h0
`define OPC_ADD_FILE  4'h1
`define OPC_SUB_FILE  4'h2
`define OPC_AND_FILE  4'h3
`define OPC_IOR_FILE  4'h4
`define OPC_XOR_FILE  4'h5
`define OPC_RLC_FILE  4'h6
`define OPC_RRC_FILE  4'h7
`define OPC_MOV_FILE  4'h8
`define OPC_STORE_ACC 4'h9
`define OPC_ADD_LIT   4'ha
`define OPC_SUB_LIT   4'hb
`define OPC_MOV_LIT   4'hc
`define OPC_MUL_FILE  4'hd
`define OPC_MOVE_FF   4'he
`define OPC_GOTO      4'hf

// Reset values.
`define RST_BYTE      8'h00
`define RST_WORD      16'h0000
`define ZERO_WORD     32'h0000_0000

`endif

/* File: core_pkg.sv */
// Types shared by the core and its arithmetic unit.
// No dependencies.
package core_pkg;

    typedef enum logic [2:0] {
        ALU_ADD,
        ALU_SUB,
        ALU_AND,
        ALU_IOR,
        ALU_XOR,
        ALU_RLC,
        ALU_RRC,
        ALU_PASS
    } alu_op_t;

    typedef enum logic [1:0] {
        MODE_INTERNAL,
        MODE_PROTECTED,
        MODE_EXTERNAL,
        MODE_EXTENDED
    } fetch_mode_t;

    // Bit 3 down to bit 0 of the arithmetic status register.
    typedef struct packed {
        logic ov;
        logic z;
        logic dc;
        logic c;
    } flags_t;

    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] data;
    } dm_write_t;

endpackage : core_pkg

/* File: cpu_core.sv */
// Byte-wide processor core: fetch stage, execute stage, special registers
// and an APB window onto them.
// Assumes program and data memories that answer combinationally in the
// cycle in which they are addressed, and an APB master on clock_i.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "core_params.svh"

module cpu_core #(
    parameter logic [16:0] INT_WORDS = 17'h02000
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    // APB register port
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Program memory bus
    output logic      [15:0] pm_addr_o,
    output logic             pm_rd_o,
    output logic             pm_ext_o,
    output logic             code_protect_o,
    input  wire logic [15:0] pm_data_i,
    // Data memory bus
    output logic      [7:0]  dm_raddr_o,
    input  wire logic [7:0]  dm_rdata_i,
    output logic             dm_we_o,
    output logic      [7:0]  dm_waddr_o,
    output logic      [7:0]  dm_wdata_o
);
    logic                  run;
    core_pkg::fetch_mode_t fetch_mode;
    logic [15:0]           program_counter;
    logic [15:0]           next_pc;
    logic [7:0]            accumulator_register;
    core_pkg::flags_t      arith_status_register;
    core_pkg::flags_t      next_status;
    logic [15:0]           instr;
    logic                  instr_valid;
    logic [15:0]           product;
    core_pkg::dm_write_t   dm_write;

    logic [3:0]            opcode;
    logic [7:0]            operand;
    logic                  exec;
    logic [7:0]            file_value;
    core_pkg::alu_op_t     alu_op;
    logic [7:0]            alu_b;
    logic [7:0]            alu_result;
    core_pkg::flags_t      alu_flags;
    core_pkg::flags_t      alu_affect;
    logic                  result_en;
    logic                  to_file;
    logic                  flags_en;
    logic                  mul_en;
    logic                  branch;
    logic                  sfr_write;
    logic                  flush;

    logic                  apb_access;
    logic                  apb_wr;
    logic                  apb_pc_wr;
    logic [31:0]           rd_data;
    logic                  rd_mapped;

    assign pm_addr_o  = program_counter;
    assign pm_rd_o    = run;
    assign dm_we_o    = dm_write.we;
    assign dm_waddr_o = dm_write.addr;
    assign dm_wdata_o = dm_write.data;

    assign opcode     = instr[15:12];
    assign operand    = instr[7:0];
    assign exec       = instr_valid & run;
    assign apb_access = psel_i & penable_i;
    assign apb_wr     = apb_access & pready_o & pwrite_i;
    assign apb_pc_wr  = apb_wr & (paddr_i == `OFS_PC);

    function automatic logic [7:0] sfr_read(input logic [7:0] addr);
        case (addr)
            `SFR_ACC:     sfr_read = accumulator_register;
            `SFR_STATUS:  sfr_read = {4'h0, arith_status_register};
            `SFR_PC_LO:   sfr_read = program_counter[7:0];
            `SFR_PC_HI:   sfr_read = program_counter[15:8];
            `SFR_PROD_LO: sfr_read = product[7:0];
            default:      sfr_read = product[15:8];
        endcase
    endfunction : sfr_read

    function automatic logic fetch_external(input logic [15:0] addr);
        unique case (fetch_mode)
            core_pkg::MODE_INTERNAL:  fetch_external = 1'b0;
            core_pkg::MODE_PROTECTED: fetch_external = 1'b0;
            core_pkg::MODE_EXTERNAL:  fetch_external = 1'b1;
            core_pkg::MODE_EXTENDED:  fetch_external = ({1'b0, addr} >= INT_WORDS);
        endcase
    endfunction : fetch_external

    // The data write of the previous instruction lands at this cycle's edge,
    // so a read of the same location takes the value still in flight.
    always_comb begin
        if (dm_raddr_o <= `SFR_LAST) begin
            file_value = sfr_read(dm_raddr_o);
        end else if (dm_write.we && dm_write.addr == dm_raddr_o) begin
            file_value = dm_write.data;
        end else begin
            file_value = dm_rdata_i;
        end
    end

    always_comb begin
        alu_op    = core_pkg::ALU_PASS;
        alu_b     = file_value;
        result_en = 1'b1;
        to_file   = instr[`DEST_BIT];
        flags_en  = 1'b1;
        mul_en    = 1'b0;
        branch    = 1'b0;
        unique case (opcode)
            `OPC_NOP: begin
                result_en = 1'b0;
                flags_en  = 1'b0;
            end
            `OPC_ADD_FILE:  alu_op = core_pkg::ALU_ADD;
            `OPC_SUB_FILE:  alu_op = core_pkg::ALU_SUB;
            `OPC_AND_FILE:  alu_op = core_pkg::ALU_AND;
            `OPC_IOR_FILE:  alu_op = core_pkg::ALU_IOR;
            `OPC_XOR_FILE:  alu_op = core_pkg::ALU_XOR;
            `OPC_RLC_FILE:  alu_op = core_pkg::ALU_RLC;
            `OPC_RRC_FILE:  alu_op = core_pkg::ALU_RRC;
            `OPC_MOV_FILE:  alu_op = core_pkg::ALU_PASS;
            `OPC_STORE_ACC: begin
                alu_b    = accumulator_register;
                to_file  = 1'b1;
                flags_en = 1'b0;
            end
            `OPC_ADD_LIT: begin
                alu_op  = core_pkg::ALU_ADD;
                alu_b   = operand;
                to_file = 1'b0;
            end
            `OPC_SUB_LIT: begin
                alu_op  = core_pkg::ALU_SUB;
                alu_b   = operand;
                to_file = 1'b0;
            end
            `OPC_MOV_LIT: begin
                alu_b    = operand;
                to_file  = 1'b0;
                flags_en = 1'b0;
            end
            `OPC_MUL_FILE: begin
                result_en = 1'b0;
                flags_en  = 1'b0;
                mul_en    = 1'b1;
            end
            `OPC_MOVE_FF: begin
                to_file  = 1'b1;
                flags_en = 1'b0;
            end
            `OPC_GOTO: begin
                result_en = 1'b0;
                flags_en  = 1'b0;
                branch    = 1'b1;
            end
        endcase
    end

    alu_unit alu (
        .a_i      (accumulator_register),
        .b_i      (alu_b),
        .carry_i  (arith_status_register.c),
        .op_i     (alu_op),
        .result_o (alu_result),
        .flags_o  (alu_flags),
        .affect_o (alu_affect)
    );

    mul_unit #(
        .WIDTH (8)
    ) mul (
        .clock_i   (clock_i),
        .resetn_i  (resetn_i),
        .enable_i  (exec & mul_en),
        .a_i       (accumulator_register),
        .b_i       (file_value),
        .product_o (product)
    );

    assign sfr_write = exec & result_en & to_file & (operand <= `SFR_LAST);
    // Writing either half of the counter is a jump and costs a bubble.
    assign flush = exec & (branch | (sfr_write & ((operand == `SFR_PC_LO) | (operand == `SFR_PC_HI))));

    always_comb begin
        next_pc = program_counter;
        if (apb_pc_wr) begin
            next_pc = pwdata_i[15:0];
        end else if (exec && branch) begin
            next_pc = {program_counter[15:8], operand};
        end else if (sfr_write && operand == `SFR_PC_LO) begin
            next_pc = {program_counter[15:8], alu_result};
        end else if (sfr_write && operand == `SFR_PC_HI) begin
            next_pc = {alu_result, program_counter[7:0]};
        end else if (run) begin
            next_pc = program_counter + 16'h0001;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            program_counter <= `RST_WORD;
            pm_ext_o        <= 1'b0;
            code_protect_o  <= 1'b0;
        end else begin
            program_counter <= next_pc;
            pm_ext_o        <= fetch_external(next_pc);
            code_protect_o  <= (fetch_mode == core_pkg::MODE_PROTECTED);
        end
    end

    // Fetch stage: the whole word is taken while the previous one executes.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            instr       <= `RST_WORD;
            instr_valid <= 1'b0;
            dm_raddr_o  <= `RST_BYTE;
        end else if (!run || flush || apb_pc_wr) begin
            instr_valid <= 1'b0;
        end else begin
            instr       <= pm_data_i;
            instr_valid <= 1'b1;
            // The operand address goes out now so the data bus works in parallel.
            if (pm_data_i[15:12] == `OPC_MOVE_FF) begin
                dm_raddr_o <= {4'h0, pm_data_i[11:8]};
            end else begin
                dm_raddr_o <= pm_data_i[7:0];
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            accumulator_register <= `RST_BYTE;
        end else if (exec && result_en && !to_file) begin
            accumulator_register <= alu_result;
        end else if (sfr_write && operand == `SFR_ACC) begin
            accumulator_register <= alu_result;
        end else if (apb_wr && paddr_i == `OFS_ACC) begin
            accumulator_register <= pwdata_i[7:0];
        end
    end

    // Flags computed by the instruction win over a direct write of the register.
    always_comb begin
        next_status = arith_status_register;
        if (sfr_write && operand == `SFR_STATUS) begin
            next_status = alu_result[3:0];
        end else if (apb_wr && paddr_i == `OFS_STATUS) begin
            next_status = pwdata_i[3:0];
        end
        if (exec && flags_en) begin
            next_status = (next_status & ~alu_affect) | (alu_flags & alu_affect);
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            arith_status_register <= '0;
        end else begin
            arith_status_register <= next_status;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dm_write <= '0;
        end else begin
            dm_write.we   <= exec & result_en & to_file & (operand > `SFR_LAST);
            dm_write.addr <= operand;
            dm_write.data <= alu_result;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run        <= 1'b0;
            fetch_mode <= core_pkg::MODE_INTERNAL;
        end else if (apb_wr && paddr_i == `OFS_CTRL) begin
            run        <= pwdata_i[`CTRL_RUN];
            fetch_mode <= core_pkg::fetch_mode_t'(pwdata_i[`CTRL_MODE_HI:`CTRL_MODE_LO]);
        end
    end

    always_comb begin
        rd_data   = `ZERO_WORD;
        rd_mapped = 1'b1;
        case (paddr_i)
            `OFS_CTRL: begin
                rd_data[`CTRL_RUN]                  = run;
                rd_data[`CTRL_MODE_HI:`CTRL_MODE_LO] = fetch_mode;
            end
            `OFS_ACC:     rd_data[7:0]  = accumulator_register;
            `OFS_STATUS:  rd_data[3:0]  = arith_status_register;
            `OFS_PC:      rd_data[15:0] = program_counter;
            `OFS_PRODUCT: rd_data[15:0] = product;
            `OFS_CORE: begin
                rd_data[`CORE_EXT]   = pm_ext_o;
                rd_data[`CORE_PROT]  = code_protect_o;
                rd_data[`CORE_VALID] = instr_valid;
            end
            default: rd_mapped = 1'b0;
        endcase
    end

    // One wait state: ready rises in the second access cycle, with data.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= `ZERO_WORD;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= apb_access & ~pready_o;
            if (apb_access && !pready_o) begin
                prdata_o  <= pwrite_i ? `ZERO_WORD : rd_data;
                pslverr_o <= ~rd_mapped;
            end
        end
    end

    logic [8:0]  chk_sum;
    logic        chk_carry;
    logic        chk_ov;
    logic        chk_no_borrow;
    logic [15:0] chk_prod;

    assign chk_sum       = {1'b0, accumulator_register} + {1'b0, file_value};
    assign chk_carry     = chk_sum[8];
    assign chk_ov        = (accumulator_register[7] == file_value[7]) && (chk_sum[7] != file_value[7]);
    assign chk_no_borrow = (file_value >= accumulator_register);
    assign chk_prod      = 16'(accumulator_register) * 16'(file_value);

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    add_carry_a: assert property (
        exec && opcode == `OPC_ADD_FILE |=> arith_status_register.c == $past(chk_carry))
        else $error("Carry after addition is wrong.");

    sub_borrow_a: assert property (
        exec && opcode == `OPC_SUB_FILE |=> arith_status_register.c == $past(chk_no_borrow))
        else $error("Borrow after subtraction is wrong.");

    signed_overflow_a: assert property (
        exec && opcode == `OPC_ADD_FILE |=> arith_status_register.ov == $past(chk_ov))
        else $error("Overflow after addition is wrong.");

    zero_flag_a: assert property (
        exec && flags_en && alu_affect.z |=> arith_status_register.z == ($past(alu_result) == 8'h00))
        else $error("Zero flag does not match the result.");

    product_ready_a: assert property (
        exec && mul_en |=> product == $past(chk_prod))
        else $error("Product not ready one cycle later.");

    branch_bubble_a: assert property (
        exec && branch && !apb_pc_wr |=> !instr_valid && program_counter[7:0] == $past(operand))
        else $error("Branch did not insert one bubble.");

    fetch_overlap_a: assert property (
        run && !flush && !apb_pc_wr |=> instr_valid && instr == $past(pm_data_i))
        else $error("Fetched word not taken while executing.");

    move_direct_a: assert property (
        exec && opcode == `OPC_MOVE_FF && operand > `SFR_LAST && !apb_wr
        |=> dm_we_o && dm_wdata_o == $past(file_value) && $stable(accumulator_register))
        else $error("File to file move went wrong.");

    no_protect_a: assert property (
        fetch_mode == core_pkg::MODE_EXTENDED |=> !code_protect_o)
        else $error("Protection active in combined mode.");

    external_fetch_a: assert property (
        fetch_mode == core_pkg::MODE_EXTERNAL && $stable(fetch_mode) |-> pm_ext_o)
        else $error("External mode fetched internally.");

endmodule : cpu_core

`default_nettype wire

/* File: mem_model.sv */
// Program and data memories on the far side of the core's two buses.
// Both answer combinationally; the bench loads them by hierarchical access.
`timescale 1ns/10ps
`default_nettype none

module mem_model (
    // Clock
    input  wire logic        clock_i,
    // Program memory bus
    input  wire logic [15:0] pm_addr_i,
    input  wire logic        pm_rd_i,
    output logic      [15:0] pm_data_o,
    // Data memory bus
    input  wire logic [7:0]  dm_raddr_i,
    output logic      [7:0]  dm_rdata_o,
    input  wire logic        dm_we_i,
    input  wire logic [7:0]  dm_waddr_i,
    input  wire logic [7:0]  dm_wdata_i
);
    logic [15:0] pm [65536];
    logic [7:0]  dm [256];

    // Unfetched words hold no-operations so a running core idles safely.
    initial begin
        foreach (pm[i]) pm[i] = 16'h0000;
        foreach (dm[i]) dm[i] = 8'h00;
    end

    // An idle fetch bus shows inverted data, never a stale word.
    assign pm_data_o  = pm_rd_i ? pm[pm_addr_i] : ~pm[pm_addr_i];
    assign dm_rdata_o = dm[dm_raddr_i];

    always @(posedge clock_i) begin
        if (dm_we_i) dm[dm_waddr_i] <= dm_wdata_i;
    end
endmodule : mem_model

`default_nettype wire

/* File: mul_unit.sv */
// Unsigned multiplier whose product lands in a register in one cycle.
// Operands must be stable in the cycle in which enable_i is high.
`timescale 1ns/10ps
`default_nettype none

module mul_unit #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic               clock_i,
    input  wire logic               resetn_i,
    // Operands
    input  wire logic               enable_i,
    input  wire logic [WIDTH-1:0]   a_i,
    input  wire logic [WIDTH-1:0]   b_i,
    // Product
    output logic      [2*WIDTH-1:0] product_o
);
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            product_o <= '0;
        end else if (enable_i) begin
            product_o <= (2*WIDTH)'(a_i) * (2*WIDTH)'(b_i);
        end
    end

endmodule : mul_unit

`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the core: APB master, memories, arithmetic model.
// Assumes mem_model and the core's sources are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "core_params.svh"

module tb;
    logic        clock_i = 1'b0, resetn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [7:0]  paddr = 8'h00, dm_raddr, dm_rdata, dm_waddr, dm_wdata;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic        pready, pslverr, pm_rd, dm_we;
    logic [15:0] pm_addr, pm_data;
    int          n_fail = 0, n_tests = 0, cycles = 0, seed = 32'h4a1f7dfc;

    cpu_core i_cpu_core (.clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .pm_addr_o(pm_addr), .pm_rd_o(pm_rd), .pm_ext_o(), .code_protect_o(),
        .pm_data_i(pm_data), .dm_raddr_o(dm_raddr), .dm_rdata_i(dm_rdata), .dm_we_o(dm_we),
        .dm_waddr_o(dm_waddr), .dm_wdata_o(dm_wdata));
    mem_model i_mem_model (.clock_i(clock_i), .pm_addr_i(pm_addr), .pm_rd_i(pm_rd), .pm_data_o(pm_data),
        .dm_raddr_i(dm_raddr), .dm_rdata_o(dm_rdata), .dm_we_i(dm_we), .dm_waddr_i(dm_waddr),
        .dm_wdata_i(dm_wdata));

    always #12.5 clock_i = ~clock_i;

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One transfer; read data and error are taken at the ready edge only.
    // A slave that never answers is caught by the bench's cycle ceiling.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do begin
            @(posedge clock_i);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Starts at address zero; the core sees exactly four fetch edges before the halt lands.
    task automatic go;
        apb(1'b1, `OFS_PC, 32'h0);
        apb(1'b1, `OFS_CTRL, 32'h1);
        apb(1'b1, `OFS_CTRL, 32'h0);
    endtask : go

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        logic [3:0]  ops [12];
        logic [3:0]  op, st, s;
        logic [7:0]  a, x, y;
        logic [8:0]  r;
        logic        sub, file, lit;
        ops = '{`OPC_ADD_LIT, `OPC_SUB_LIT, `OPC_ADD_FILE, `OPC_SUB_FILE, `OPC_MUL_FILE, `OPC_AND_FILE,
                `OPC_IOR_FILE, `OPC_XOR_FILE, `OPC_RLC_FILE, `OPC_RRC_FILE, `OPC_MOV_LIT, `OPC_STORE_ACC};
        repeat (4) @(posedge clock_i);
        resetn_i <= 1'b1;
        apb(1'b0, `OFS_STATUS, 32'h0); chk("status reset", 32'h0, q);
        apb(1'b0, `OFS_ACC, 32'h0); chk("acc reset", 32'h0, q);
        apb(1'b0, 8'h18, 32'h0); chk("unmapped error", 32'h1, {31'h0, err});
        for (int k = 0; k < 150; k++) begin
            op = ops[k % 12];
            a = 8'($random(seed));
            x = (k < 5) ? 8'h7f : 8'($random(seed));
            s = 4'($random(seed));
            lit = op inside {`OPC_ADD_LIT, `OPC_SUB_LIT, `OPC_MOV_LIT};
            file = !lit && (op != `OPC_MUL_FILE);
            i_mem_model.dm[8'h40] = x;
            i_mem_model.pm[0] = {op, 3'b000, file, lit ? x : 8'h40};
            // Flags that an operation leaves alone must keep this random start value.
            apb(1'b1, `OFS_STATUS, {28'h0, s});
            apb(1'b1, `OFS_ACC, {24'h0, a});
            go();
            sub = (op == `OPC_SUB_LIT) || (op == `OPC_SUB_FILE);
            y = sub ? ~a : a;
            r = x + y + sub;
            st = {(x[7] == y[7]) && (r[7] != x[7]), r[7:0] == 8'h00, (5'(x[3:0]) + y[3:0] + sub) > 5'h0f, r[8]};
            if (op inside {`OPC_AND_FILE, `OPC_IOR_FILE, `OPC_XOR_FILE}) begin
                r[7:0] = (op == `OPC_AND_FILE) ? (a & x) : (op == `OPC_IOR_FILE) ? (a | x) : (a ^ x);
                st = {s[3], r[7:0] == 8'h00, s[1:0]};
            end else if (op inside {`OPC_RLC_FILE, `OPC_RRC_FILE}) begin
                r = (op == `OPC_RLC_FILE) ? {x, s[0]} : {x[0], s[0], x[7:1]};
                st = {s[3:1], r[8]};
            end else if (op inside {`OPC_MOV_LIT, `OPC_STORE_ACC}) begin
                r = {1'b0, (op == `OPC_MOV_LIT) ? x : a};
                st = s;
            end
            if (op == `OPC_MUL_FILE) begin
                apb(1'b0, `OFS_PRODUCT, 32'h0); chk("product", {16'h0, {8'h0, a} * {8'h0, x}}, q);
            end else begin
                apb(1'b0, `OFS_STATUS, 32'h0); chk("status", {28'h0, st}, q);
                apb(1'b0, `OFS_ACC, 32'h0); chk("acc", {24'h0, file ? a : r[7:0]}, q);
                if (file) chk("file byte", {24'h0, r[7:0]}, {24'h0, i_mem_model.dm[8'h40]});
            end
        end
        // A jump throws away the word fetched behind it and runs its target.
        i_mem_model.pm[0] = {`OPC_GOTO, 4'h0, 8'h20};
        i_mem_model.pm[16'h0020] = {`OPC_MOV_LIT, 4'h0, 8'h5a};
        go();
        apb(1'b0, `OFS_ACC, 32'h0);
        chk("acc after jump", 32'h5a, q);
        y = 8'($random(seed));
        i_mem_model.dm[8'h08] = y;
        i_mem_model.pm[0] = {`OPC_MOVE_FF, 4'h8, 8'h41};
        go();
        chk("moved byte", {24'h0, y}, {24'h0, i_mem_model.dm[8'h41]});
        apb(1'b0, `OFS_ACC, 32'h0);
        chk("acc kept", 32'h5a, q);
        apb(1'b1, `OFS_CTRL, 32'h10);
        apb(1'b0, `OFS_CORE, 32'h0);
        chk("protected fetch", 32'h2, q);
        apb(1'b1, `OFS_CTRL, 32'h20);
        apb(1'b0, `OFS_CORE, 32'h0);
        chk("external fetch", 32'h1, q);
        apb(1'b1, `OFS_CTRL, 32'h30);
        apb(1'b0, `OFS_CORE, 32'h0);
        chk("combined low", 32'h0, q);
        apb(1'b1, `OFS_PC, 32'hffff);
        apb(1'b0, `OFS_CORE, 32'h0);
        chk("combined high", 32'h1, q);
        results();
    end
endmodule : tb

`default_nettype wire
